/* src/csd_clock_switch.sv */
`timescale 1ns/10ps
module csd_clock_switch
  import csd_pkg::*;
#(
  parameter int OST_LEN = OST_CYCLES
)
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire csd_bus_req_t bus_req,
  output logic [15:0] rdata_ff,
  input wire logic switching_config_bit,
  input wire logic failsafe_clock_monitor_config_bit,
  input wire logic [2:0] boot_source_config,
  input wire logic wdt_uses_low_power_rc_oscillator,
  input wire logic pll_locked,
  input wire logic new_clk_sample,
  input wire logic clock_fail_detect,
  input wire logic irq_event,
  output logic [2:0] current_source_sel_ff,
  output csd_osc_en_t osc_en_ff,
  output logic [2:0] doze_ratio_ff,
  output logic [2:0] fast_rc_postscale_ff,
  output logic lp_base_sel_ff,
  output logic [5:0] fast_rc_trim_ff,
  output logic clock_fail_event_ff
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_WAIT_OST,
    ST_WAIT_PLL,
    ST_SETTLE
  } csd_state_t;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic uses_pll(input logic [2:0] s);
    uses_pll = (s == SRC_FAST_RC_WITH_PLL_MODE) || (s == SRC_PRIPLL);
  endfunction

  function automatic csd_osc_en_t osc_of(input logic [2:0] s);
    csd_osc_en_t e;
    e = '0;
    case (s)
      SRC_FRC, SRC_FRCDIV, SRC_LPFRCDIV: e.fast_rc_oscillator = 1'b1;
      SRC_FAST_RC_WITH_PLL_MODE:
      begin
        e.fast_rc_oscillator = 1'b1;
        e.pll = 1'b1;
      end
      SRC_PRI: e.pri = 1'b1;
      SRC_PRIPLL:
      begin
        e.pri = 1'b1;
        e.pll = 1'b1;
      end
      SRC_SEC: e.sec = 1'b1;
      SRC_LOW_POWER_RC_OSCILLATOR: e.low_power_rc_oscillator = 1'b1;
      default: e = '0;
    endcase
    osc_of = e;
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  csd_state_t state_ff;
  logic [2:0] req_src_ff;
  logic swreq_ff;
  logic sellock_ff;
  logic plllock_ff;
  logic fail_ff;
  logic soscdrv_ff;
  logic secondary_osc_enable_ff;
  logic roi_ff;
  logic ratio_divide_enable_ff;
  logic [2:0] doze_ff;
  logic [2:0] rcdiv_ff;
  logic [5:0] trim_ff;
  logic hi_key_ff;
  logic hi_open_ff;
  logic lo_key_ff;
  logic lo_open_ff;
  logic [13:0] ost_ff;
  logic fail_d_ff;
  logic settle_done;
  logic cnt_clr;

  logic sw_enable;
  logic failsafe_clock_monitor_on;
  logic wr_hi;
  logic wr_lo;
  logic hi_write_ok;
  logic lo_write_ok;
  logic start_req;

  assign sw_enable = !switching_config_bit;
  assign failsafe_clock_monitor_on = !switching_config_bit && !failsafe_clock_monitor_config_bit;
  assign wr_hi = bus_req.wr && (bus_req.addr == OSC_HI_ADDR);
  assign wr_lo = bus_req.wr && (bus_req.addr == OSC_LO_ADDR);
  assign hi_write_ok = wr_hi && hi_open_ff;
  assign lo_write_ok = wr_lo && lo_open_ff;
  assign start_req = lo_write_ok && bus_req.wdata[SWREQ_BIT] && sw_enable
                     && !(failsafe_clock_monitor_on && sellock_ff) && state_ff == ST_IDLE;
  assign cnt_clr = (state_ff != ST_SETTLE);

  csd_edge_count csd_edge_count_inst
  (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clr(cnt_clr),
    .clk_sample(new_clk_sample),
    .done_ff(settle_done)
  );

  // ---------------------------------------------------------------
  // unlock windows
  // ---------------------------------------------------------------
  // one-access windows
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      hi_key_ff <= 1'b0;
      hi_open_ff <= 1'b0;
      lo_key_ff <= 1'b0;
      lo_open_ff <= 1'b0;
    end
    else if (bus_req.wr || bus_req.rd)
    begin
      hi_key_ff <= wr_hi && !hi_open_ff && bus_req.wdata[7:0] == HI_KEY1;
      hi_open_ff <= wr_hi && hi_key_ff && bus_req.wdata[7:0] == HI_KEY2;
      lo_key_ff <= wr_lo && !lo_open_ff && bus_req.wdata[7:0] == LO_KEY1;
      lo_open_ff <= wr_lo && lo_key_ff && bus_req.wdata[7:0] == LO_KEY2;
    end
  end

  // ---------------------------------------------------------------
  // switch sequencer
  // ---------------------------------------------------------------
  // no stall output; cpu keeps running
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_ff <= ST_IDLE;
      swreq_ff <= 1'b0;
      ost_ff <= '0;
    end
    else
    begin
      case (state_ff)
        ST_IDLE:
        begin
          if (start_req)
          begin
            if (req_src_ff == current_source_sel_ff)
              swreq_ff <= 1'b0;
            else
            begin
              swreq_ff <= 1'b1;
              state_ff <= ST_START;
            end
          end
          else
            swreq_ff <= 1'b0;
        end
        ST_START:
        begin
          ost_ff <= 14'(OST_LEN);
          if (req_src_ff == SRC_PRI || req_src_ff == SRC_PRIPLL)
            state_ff <= ST_WAIT_OST;
          else if (uses_pll(req_src_ff))
            state_ff <= ST_WAIT_PLL;
          else
            state_ff <= ST_SETTLE;
        end
        ST_WAIT_OST:
        begin
          if (ost_ff != '0)
            ost_ff <= ost_ff - 14'h1;
          else if (uses_pll(req_src_ff))
            state_ff <= ST_WAIT_PLL;
          else
            state_ff <= ST_SETTLE;
        end
        ST_WAIT_PLL:
        begin
          if (pll_locked)
            state_ff <= ST_SETTLE;
        end
        ST_SETTLE:
        begin
          if (settle_done)
          begin
            swreq_ff <= 1'b0;
            state_ff <= ST_IDLE;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      current_source_sel_ff <= SRC_FRCDIV;
    else if (!sw_enable)
      current_source_sel_ff <= boot_source_config;
    else if (state_ff == ST_SETTLE && settle_done)
      current_source_sel_ff <= req_src_ff;
  end

  // latch boot source once after reset release, whether or not switching is enabled
  logic boot_taken_ff;
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      boot_taken_ff <= 1'b0;
      req_src_ff <= SRC_FRCDIV;
    end
    else if (!boot_taken_ff)
    begin
      boot_taken_ff <= 1'b1;
      req_src_ff <= boot_source_config;
    end
    else if (hi_write_ok)
      req_src_ff <= bus_req.wdata[10:8];
  end

  // ---------------------------------------------------------------
  // oscillator enables
  // ---------------------------------------------------------------
  // old source stopped except exempt ones
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      osc_en_ff <= '0;
    else
    begin
      osc_en_ff <= osc_of(current_source_sel_ff)
                   | (state_ff != ST_IDLE ? osc_of(req_src_ff) : '0);
      if (secondary_osc_enable_ff)
        osc_en_ff.sec <= 1'b1;
      if (wdt_uses_low_power_rc_oscillator || failsafe_clock_monitor_on)
        osc_en_ff.low_power_rc_oscillator <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // status flags
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      plllock_ff <= 1'b0;
      fail_ff <= 1'b0;
      fail_d_ff <= 1'b0;
      clock_fail_event_ff <= 1'b0;
    end
    else
    begin
      // clear on valid start; lock low on non-pll
      if (state_ff == ST_START || !uses_pll(current_source_sel_ff))
        plllock_ff <= 1'b0;
      else
        plllock_ff <= pll_locked;
      if (failsafe_clock_monitor_on && clock_fail_detect)
        fail_ff <= 1'b1;
      else if (state_ff == ST_START)
        fail_ff <= 1'b0;
      else if (lo_write_ok && !bus_req.wdata[FAIL_BIT])
        fail_ff <= 1'b0;
      fail_d_ff <= fail_ff;
      clock_fail_event_ff <= fail_ff && !fail_d_ff;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sellock_ff <= 1'b0;
      soscdrv_ff <= 1'b0;
      secondary_osc_enable_ff <= 1'b0;
    end
    else if (lo_write_ok)
    begin
      sellock_ff <= sellock_ff | bus_req.wdata[SELLOCK_BIT];
      soscdrv_ff <= bus_req.wdata[SOSCDRV_BIT];
      secondary_osc_enable_ff <= bus_req.wdata[SECONDARY_OSC_ENABLE_BIT];
    end
  end

  // ---------------------------------------------------------------
  // divider and trim registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      roi_ff <= 1'b0;
      ratio_divide_enable_ff <= 1'b0;
      doze_ff <= DOZE_RST;
      rcdiv_ff <= RCDIV_RST;
    end
    else
    begin
      if (bus_req.wr && bus_req.addr == CLK_DIV_ADDR)
      begin
        roi_ff <= bus_req.wdata[ROI_BIT];
        doze_ff <= bus_req.wdata[DOZE_LSB +: 3];
        ratio_divide_enable_ff <= bus_req.wdata[RATIO_DIVIDE_ENABLE_BIT];
        rcdiv_ff <= bus_req.wdata[RCDIV_LSB +: 3];
      end
      if (roi_ff && irq_event)
        ratio_divide_enable_ff <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      trim_ff <= TRIM_RST;
    else if (bus_req.wr && bus_req.addr == TRIM_ADDR)
      trim_ff <= bus_req.wdata[5:0];
  end

  // ---------------------------------------------------------------
  // clock control outputs
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      doze_ratio_ff <= 3'h0;
      fast_rc_postscale_ff <= RCDIV_RST;
      lp_base_sel_ff <= 1'b0;
      fast_rc_trim_ff <= TRIM_RST;
    end
    else
    begin
      // ratio log2 code, 1:1 unless enabled
      doze_ratio_ff <= ratio_divide_enable_ff ? doze_ff : 3'h0;
      fast_rc_postscale_ff <= rcdiv_ff;
      lp_base_sel_ff <= (current_source_sel_ff == SRC_LPFRCDIV);
      fast_rc_trim_ff <= trim_ff;
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      rdata_ff <= 16'h0000;
    else if (bus_req.rd)
    begin
      case (bus_req.addr)
        OSC_CTRL_ADDR, OSC_HI_ADDR, OSC_LO_ADDR:
          rdata_ff <= {1'b0, current_source_sel_ff, 1'b0, req_src_ff,
                       sellock_ff, 1'b0, plllock_ff, 1'b0, fail_ff,
                       soscdrv_ff, secondary_osc_enable_ff, swreq_ff};
        CLK_DIV_ADDR:
          rdata_ff <= {roi_ff, doze_ff, ratio_divide_enable_ff, rcdiv_ff, 8'h00};
        TRIM_ADDR:
          rdata_ff <= {10'h000, trim_ff};
        default: rdata_ff <= 16'h0000;
      endcase
    end
    else
      rdata_ff <= 16'h0000;
  end
endmodule

/* src/csd_pkg.sv */
package csd_pkg;
  // ---------------------------------------------------------------
  // register map (word addresses)
  // ---------------------------------------------------------------
  localparam logic [3:0] OSC_CTRL_ADDR = 4'h0;
  localparam logic [3:0] CLK_DIV_ADDR = 4'h1;
  localparam logic [3:0] TRIM_ADDR = 4'h2;
  localparam logic [3:0] OSC_HI_ADDR = 4'h3;
  localparam logic [3:0] OSC_LO_ADDR = 4'h4;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CUR_LSB = 12;
  localparam int REQ_LSB = 8;
  localparam int SELLOCK_BIT = 7;
  localparam int PLLLOCK_BIT = 5;
  localparam int FAIL_BIT = 3;
  localparam int SOSCDRV_BIT = 2;
  localparam int SECONDARY_OSC_ENABLE_BIT = 1;
  localparam int SWREQ_BIT = 0;
  localparam int ROI_BIT = 15;
  localparam int DOZE_LSB = 12;
  localparam int RATIO_DIVIDE_ENABLE_BIT = 11;
  localparam int RCDIV_LSB = 8;
  // ---------------------------------------------------------------
  // unlock keys and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] HI_KEY1 = 8'h78;
  localparam logic [7:0] HI_KEY2 = 8'h9a;
  localparam logic [7:0] LO_KEY1 = 8'h46;
  localparam logic [7:0] LO_KEY2 = 8'h57;
  localparam logic [2:0] DOZE_RST = 3'h3;
  localparam logic [2:0] RCDIV_RST = 3'h1;
  localparam logic [5:0] TRIM_RST = 6'h00;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int SETTLE_CYCLES = 10;
  localparam int CLK_PERIOD_NS = 10;
  localparam int OST_TIME_NS = 10240;
  localparam int OST_CYCLES = (OST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  // source code map
  typedef enum logic [2:0] {
    SRC_FRC = 3'h0,
    SRC_FAST_RC_WITH_PLL_MODE = 3'h1,
    SRC_PRI = 3'h2,
    SRC_PRIPLL = 3'h3,
    SRC_SEC = 3'h4,
    SRC_LOW_POWER_RC_OSCILLATOR = 3'h5,
    SRC_LPFRCDIV = 3'h6,
    SRC_FRCDIV = 3'h7
  } csd_src_t;
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } csd_bus_req_t;
  typedef struct packed {
    logic fast_rc_oscillator;
    logic pll;
    logic pri;
    logic sec;
    logic low_power_rc_oscillator;
  } csd_osc_en_t;
endpackage

/* src/csd_edge_count.sv */
`timescale 1ns/10ps
// counts rising edges of a synchronised clock sample
module csd_edge_count
  import csd_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clr,
  input wire logic clk_sample,
  output logic done_ff
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic [3:0] cnt_ff;

  // s1 only feeds s2
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end
    else
    begin
      s1_ff <= clk_sample;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_ff <= 4'h0;
      done_ff <= 1'b0;
    end
    else if (clr)
    begin
      cnt_ff <= 4'h0;
      done_ff <= 1'b0;
    end
    else if (s2_ff && !s3_ff && !done_ff)
    begin
      cnt_ff <= cnt_ff + 4'h1;
      done_ff <= (cnt_ff == 4'(SETTLE_CYCLES - 1));
    end
  end
endmodule

/* tb/csd_monitor.sv */
`timescale 1ns/10ps
module csd_monitor
  import csd_pkg::*;
#(
  parameter int OST_LEN = OST_CYCLES
)
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire csd_bus_req_t bus_req,
  input wire logic [15:0] rdata_ff,
  input wire logic switching_config_bit,
  input wire logic [2:0] boot_source_config,
  input wire logic clock_fail_detect,
  input wire logic irq_event,
  input wire logic [2:0] current_source_sel_ff,
  input wire logic [2:0] doze_ratio_ff,
  input wire logic [2:0] fast_rc_postscale_ff,
  input wire logic lp_base_sel_ff,
  input wire logic [5:0] fast_rc_trim_ff,
  input wire logic clock_fail_event_ff
);
  logic [1:0] alive_ff;
  logic roi_ff;
  logic [3:0] fail_hist_ff;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // boot value lands one cycle after release, so wait a few edges
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      alive_ff <= 2'h0;
    else if (alive_ff != 2'h3)
      alive_ff <= alive_ff + 2'h1;
  end
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      roi_ff <= 1'b0;
    else if (bus_req.wr && bus_req.addr == CLK_DIV_ADDR)
      roi_ff <= bus_req.wdata[ROI_BIT];
  end
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      fail_hist_ff <= 4'h0;
    else
      fail_hist_ff <= {fail_hist_ff[2:0], clock_fail_detect};
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  // expected outputs two edges after a divider write
  function automatic logic [2:0] doze_of(input csd_bus_req_t r);
    doze_of = r.wdata[RATIO_DIVIDE_ENABLE_BIT] ? r.wdata[DOZE_LSB +: 3] : 3'h0;
  endfunction
  function automatic logic [2:0] ps_of(input csd_bus_req_t r);
    ps_of = r.wdata[RCDIV_LSB +: 3];
  endfunction
  property doze_wr_p;
    bus_req.wr && bus_req.addr == CLK_DIV_ADDR && !irq_event
    |=> ##1 doze_ratio_ff == doze_of($past(bus_req, 2));
  endproperty
  property ps_wr_p;
    bus_req.wr && bus_req.addr == CLK_DIV_ADDR
    |=> ##1 fast_rc_postscale_ff == ps_of($past(bus_req, 2));
  endproperty
  boot_follow_a: assert property (
    alive_ff == 2'h3 && switching_config_bit && $past(switching_config_bit)
    && $stable(boot_source_config)
    |-> current_source_sel_ff == boot_source_config)
    else $error("current source differs from boot config");
  lp_base_a: assert property (
    alive_ff == 2'h3 && $stable(current_source_sel_ff)
    |-> lp_base_sel_ff == (current_source_sel_ff == SRC_LPFRCDIV))
    else $error("low power base select wrong");
  roi_clear_a: assert property (
    roi_ff && irq_event |-> ##[1:2] doze_ratio_ff == 3'h0)
    else $error("interrupt did not restore 1:1 ratio");
  roi_off_a: assert property (
    !roi_ff && irq_event && !bus_req.wr && !$past(bus_req.wr)
    && !$past(bus_req.wr, 2) |=> $stable(doze_ratio_ff) [*2])
    else $error("interrupt changed ratio without recover");
  doze_write_a: assert property (doze_wr_p)
    else $error("doze ratio output wrong after write");
  postscale_write_a: assert property (ps_wr_p)
    else $error("postscale output wrong after write");
  swreq_held_a: assert property (
    bus_req.rd && bus_req.addr == OSC_CTRL_ADDR && switching_config_bit
    |=> rdata_ff[SWREQ_BIT] == 1'b0)
    else $error("switch request readable while disabled");
  trim_read_a: assert property (
    bus_req.rd && bus_req.addr == TRIM_ADDR
    |=> rdata_ff == {10'h000, fast_rc_trim_ff})
    else $error("trim read value wrong");
  fail_pulse_a: assert property (
    clock_fail_event_ff |-> (|fail_hist_ff) ##1 !clock_fail_event_ff)
    else $error("fail event without cause or too long");
  switch_done_c: cover property (alive_ff == 2'h3
    && $changed(current_source_sel_ff) && !switching_config_bit);
  roi_hit_c: cover property (roi_ff && irq_event);
  fail_event_c: cover property (clock_fail_event_ff);
endmodule
bind csd_clock_switch csd_monitor #(.OST_LEN(OST_LEN)) csd_monitor_inst (
  .core_clk(core_clk), .sys_rst(sys_rst), .bus_req(bus_req),
  .rdata_ff(rdata_ff), .switching_config_bit(switching_config_bit),
  .boot_source_config(boot_source_config),
  .clock_fail_detect(clock_fail_detect), .irq_event(irq_event),
  .current_source_sel_ff(current_source_sel_ff),
  .doze_ratio_ff(doze_ratio_ff),
  .fast_rc_postscale_ff(fast_rc_postscale_ff),
  .lp_base_sel_ff(lp_base_sel_ff), .fast_rc_trim_ff(fast_rc_trim_ff),
  .clock_fail_event_ff(clock_fail_event_ff));

/* tb/test_clock_switch_and_doze_divider.sv */
`timescale 1ns/10ps
module test_clock_switch_and_doze_divider
  import csd_pkg::*;
;
  typedef struct packed {
    logic [3:0] a;
    logic [15:0] w;
    logic [15:0] r;
    logic [2:0] dz;
    logic [2:0] ps;
    logic [5:0] tr;
  } csd_row_t;
  localparam int CRYSTAL_STARTUP_TIMER = 4;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  csd_bus_req_t bus_req = '0;
  logic sw_cfg = 1'b1;
  logic failsafe_clock_monitor_cfg = 1'b1;
  logic [2:0] boot = 3'h7;
  logic new_clk = 1'b0;
  logic fail_det = 1'b0;
  logic irq = 1'b0;
  logic pll_lk = 1'b0;
  logic fev_seen = 1'b0;
  logic [15:0] rdata;
  logic [15:0] rword;
  logic [2:0] cur;
  csd_osc_en_t osc_en;
  logic [2:0] doze;
  logic [2:0] ps;
  logic lp;
  logic [5:0] trim;
  logic fev;
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;
  csd_row_t rows [12] = '{
    '{CLK_DIV_ADDR, 16'h0800, 16'h0800, 3'h0, 3'h0, 6'h00},
    '{CLK_DIV_ADDR, 16'h1900, 16'h1900, 3'h1, 3'h1, 6'h00},
    '{CLK_DIV_ADDR, 16'h2a00, 16'h2a00, 3'h2, 3'h2, 6'h00},
    '{CLK_DIV_ADDR, 16'h3b00, 16'h3b00, 3'h3, 3'h3, 6'h00},
    '{CLK_DIV_ADDR, 16'h4c00, 16'h4c00, 3'h4, 3'h4, 6'h00},
    '{CLK_DIV_ADDR, 16'h5d00, 16'h5d00, 3'h5, 3'h5, 6'h00},
    '{CLK_DIV_ADDR, 16'h6e00, 16'h6e00, 3'h6, 3'h6, 6'h00},
    '{CLK_DIV_ADDR, 16'h7f00, 16'h7f00, 3'h7, 3'h7, 6'h00},
    '{CLK_DIV_ADDR, 16'h7700, 16'h7700, 3'h0, 3'h7, 6'h00},
    '{TRIM_ADDR, 16'hffdf, 16'h001f, 3'h0, 3'h7, 6'h1f},
    '{TRIM_ADDR, 16'h0020, 16'h0020, 3'h0, 3'h7, 6'h20},
    '{4'h9, 16'hffff, 16'h0000, 3'h0, 3'h7, 6'h20}};
  always #5 core_clk = ~core_clk;
  csd_clock_switch #(.OST_LEN(CRYSTAL_STARTUP_TIMER)) csd_clock_switch_inst (
    .core_clk(core_clk), .sys_rst(sys_rst), .bus_req(bus_req),
    .rdata_ff(rdata), .switching_config_bit(sw_cfg),
    .failsafe_clock_monitor_config_bit(failsafe_clock_monitor_cfg), .boot_source_config(boot),
    .wdt_uses_low_power_rc_oscillator(1'b0), .pll_locked(pll_lk), .new_clk_sample(new_clk),
    .clock_fail_detect(fail_det), .irq_event(irq),
    .current_source_sel_ff(cur), .osc_en_ff(osc_en), .doze_ratio_ff(doze),
    .fast_rc_postscale_ff(ps), .lp_base_sel_ff(lp), .fast_rc_trim_ff(trim),
    .clock_fail_event_ff(fev));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task finish_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task cmp16(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cmp6(input logic [5:0] got, input logic [5:0] exp);
    cmp16({10'h000, got}, {10'h000, exp});
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    bus_req <= {a, d, 1'b1, 1'b0};
    @(posedge core_clk);
    bus_req <= '0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge core_clk);
    bus_req <= {a, 16'h0000, 1'b0, 1'b1};
    @(posedge core_clk);
    bus_req <= '0;
    #1 rword = rdata;
  endtask
  task rdc(input logic [3:0] a, input logic [15:0] exp);
    rd(a);
    cmp16(rword, exp);
  endtask
  // new clock edges are slow enough for the internal synchroniser
  task edges(input int k);
    repeat (k)
    begin
      @(posedge core_clk);
      new_clk <= 1'b1;
      repeat (2) @(posedge core_clk);
      new_clk <= 1'b0;
      @(posedge core_clk);
    end
  endtask
  task unlock_req(input logic [2:0] n, input logic [15:0] lo);
    wr(OSC_HI_ADDR, {8'h00, HI_KEY1});
    wr(OSC_HI_ADDR, {8'h00, HI_KEY2});
    wr(OSC_HI_ADDR, {5'h00, n, 8'h00});
    wr(OSC_LO_ADDR, {8'h00, LO_KEY1});
    wr(OSC_LO_ADDR, {8'h00, LO_KEY2});
    wr(OSC_LO_ADDR, lo);
  endtask
  task pulse(input int which);
    @(posedge core_clk);
    if (which == 0)
      irq <= 1'b1;
    else
      fail_det <= 1'b1;
    @(posedge core_clk);
    irq <= 1'b0;
    fail_det <= 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
  endtask
  task wait_cur(input logic [2:0] n);
    int i;
    i = 0;
    while (cur !== n && i < 40)
    begin
      @(posedge core_clk);
      i++;
    end
    #1 cmp6({3'h0, cur}, {3'h0, n});
  endtask
  // fail event is one cycle wide, so keep a sticky copy
  always @(posedge core_clk)
  begin
    if (fev)
      fev_seen <= 1'b1;
  end
  // hang guard, well above the few hundred cycles the run needs
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fail_count++;
      finish_test();
    end
  end
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    rdc(CLK_DIV_ADDR, 16'h3100);
    cmp6({3'h0, ps}, 6'h01);
    cmp6({3'h0, doze}, 6'h00);
    rdc(TRIM_ADDR, 16'h0000);
    rdc(OSC_CTRL_ADDR, 16'h7700);
    unlock_req(3'h2, 16'h0001);
    rd(OSC_CTRL_ADDR);
    cmp6({5'h00, rword[SWREQ_BIT]}, 6'h00);
    repeat (20) @(posedge core_clk);
    #1 cmp6({3'h0, cur}, 6'h07);
    boot <= 3'h6;
    repeat (3) @(posedge core_clk);
    #1 cmp6({3'h0, cur}, 6'h06);
    cmp6({5'h00, lp}, 6'h01);
    @(posedge core_clk);
    boot <= 3'h7;
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].w);
      rdc(rows[i].a, rows[i].r);
      cmp6({3'h0, doze}, {3'h0, rows[i].dz});
      cmp6({3'h0, ps}, {3'h0, rows[i].ps});
      cmp6(trim, rows[i].tr);
    end
    wr(CLK_DIV_ADDR, 16'hb900);
    pulse(0);
    cmp6({3'h0, doze}, 6'h00);
    rdc(CLK_DIV_ADDR, 16'hb100);
    wr(CLK_DIV_ADDR, 16'h3900);
    repeat (2) @(posedge core_clk);
    pulse(0);
    cmp6({3'h0, doze}, 6'h03);
    @(posedge core_clk);
    sw_cfg <= 1'b0;
    unlock_req(3'h2, 16'h0001);
    rdc(OSC_CTRL_ADDR, 16'h7201);
    cmp6({5'h00, osc_en.pri}, 6'h01);
    repeat (CRYSTAL_STARTUP_TIMER + 2) @(posedge core_clk);
    edges(9);
    repeat (6) @(posedge core_clk);
    #1 cmp6({3'h0, cur}, 6'h07);
    edges(1);
    wait_cur(3'h2);
    rdc(OSC_CTRL_ADDR, 16'h2200);
    cmp6({1'b0, osc_en}, 6'h04);
    unlock_req(3'h2, 16'h0001);
    repeat (3) @(posedge core_clk);
    rdc(OSC_CTRL_ADDR, 16'h2200);
    wr(OSC_HI_ADDR, {8'h00, HI_KEY1});
    wr(OSC_HI_ADDR, {8'h00, HI_KEY2});
    rd(CLK_DIV_ADDR);
    wr(OSC_HI_ADDR, 16'h0500);
    rdc(OSC_CTRL_ADDR, 16'h2200);
    @(posedge core_clk);
    failsafe_clock_monitor_cfg <= 1'b0;
    cmp6({5'h00, fev_seen}, 6'h00);
    pulse(1);
    cmp6({5'h00, fev_seen}, 6'h01);
    rdc(OSC_CTRL_ADDR, 16'h2208);
    // fail bit written as one so only the switch start can clear it
    unlock_req(3'h0, 16'h0009);
    rdc(OSC_CTRL_ADDR, 16'h2001);
    edges(10);
    wait_cur(3'h0);
    // pll mode entered from plain fast rc only
    unlock_req(3'h1, 16'h0001);
    repeat (5) @(posedge core_clk);
    // wait, then read request and lock status
    rdc(OSC_CTRL_ADDR, 16'h0101);
    @(posedge core_clk);
    pll_lk <= 1'b1;
    edges(10);
    wait_cur(3'h1);
    rdc(OSC_CTRL_ADDR, 16'h1120);
    unlock_req(3'h0, 16'h0080);
    unlock_req(3'h7, 16'h0001);
    edges(10);
    repeat (8) @(posedge core_clk);
    #1 cmp6({3'h0, cur}, 6'h01);
    finish_test();
  end
endmodule
